// *** gp_pkg.sv ***
// gpio block package: port geometry, reset values, request carriers
// assumes a single system clock; all ports held as 8-bit lanes
package gp_pkg;

    // ****************************************
    // port geometry
    // ****************************************
    localparam int NPORT = 7;
    localparam int PW = 8;
    localparam int PIDX_W = 3;
    localparam int BIT_W = 3;
    localparam logic [PIDX_W-1:0] P_FIRST = 3'h0;
    localparam logic [PIDX_W-1:0] P_SECOND = 3'h1;
    localparam logic [PIDX_W-1:0] P_ANALOG = 3'h2;
    localparam logic [PIDX_W-1:0] P_FOURTH = 3'h3;
    localparam logic [PIDX_W-1:0] P_OPEN_DRAIN = 3'h4;
    localparam logic [PIDX_W-1:0] P_KEY = 3'h5;
    localparam logic [PIDX_W-1:0] P_CLOCK_PIN = 3'h6;

    // implemented bits of each port (7, 8, 8, 4, 2, 8, 5 bits)
    localparam logic [PW-1:0] WIDTH_MASK [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h0f, 8'h03, 8'hff,
        8'h1f};
    // bits that carry a pull-up option
    localparam logic [PW-1:0] PULL_MASK [NPORT] = '{8'h7f, 8'hff, 8'h00, 8'h0f, 8'h00, 8'hff,
        8'h01};
    // bits of the clock pin port that the oscillators may claim
    localparam logic [PW-1:0] CLOCK_CLAIM_MASK = 8'h1e;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [PW-1:0] DIR_RESET = 8'hff;
    localparam logic [PW-1:0] LATCH_RESET = 8'h00;
    localparam logic [PW-1:0] PULL_RESET = 8'h00;
    localparam logic [PW-1:0] ANALOG_CFG_RESET = 8'hff;
    localparam logic [PW-1:0] CLOCK_MODE_PORT = 8'h00;

    // ****************************************
    // register kinds
    // ****************************************
    typedef enum logic [1:0] {
        GP_REG_DIR = 2'h0,
        GP_REG_DATA = 2'h1,
        GP_REG_PULL = 2'h2,
        GP_REG_ANALOG = 2'h3
    } gp_reg_e;

    typedef logic [NPORT-1:0][PW-1:0] gp_bank_t;

    typedef struct packed {
        logic en;
        logic bit_mode;
        gp_reg_e kind;
        logic [PIDX_W-1:0] port;
        logic [BIT_W-1:0] bit_idx;
        logic [PW-1:0] data;
    } gp_wr_s;

    typedef struct packed {
        gp_reg_e kind;
        logic [PIDX_W-1:0] port;
    } gp_rd_s;

    typedef struct packed {
        gp_bank_t out;
        gp_bank_t oe;
        gp_bank_t pull;
    } gp_pad_s;

endpackage

// *** gp_gpio.sv ***
// multi-port general-purpose i/o block with per-bit direction, latch, pull-up
// assumes pins arrive asynchronously and the register port is on clock_i
// assumes software keeps the pin-sharing order; analog misuse is flagged, not blocked; drive on claimed clock pins is blocked, not flagged
`timescale 1ns/100ps
`default_nettype none

module gp_gpio (
    input wire logic clock_i,                           // system clock, 250 MHz
    input wire logic reset_i,                           // synchronous reset, high
    input wire gp_pkg::gp_wr_s wr_i,                    // register write request
    input wire gp_pkg::gp_rd_s rd_i,                    // register read select
    output var logic [gp_pkg::PW-1:0] rd_data_o,        // read data, one cycle later
    input wire gp_pkg::gp_bank_t pin_i,                 // pin levels, asynchronous
    output var gp_pkg::gp_pad_s pad_o,                  // pad drive, enable, pull-up
    input wire logic [gp_pkg::PW-1:0] clock_mode_i,     // clock operation mode value
    input wire logic [gp_pkg::BIT_W-1:0] channel_sel_i, // converter channel select
    output var logic [gp_pkg::PW-1:0] analog_target_o,  // pins under conversion
    output var logic analog_conflict_o                  // selected analog pin in output
);
    import gp_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [PW-1:0] merge_write(input logic [PW-1:0] cur, input gp_wr_s w);
        logic [PW-1:0] res;
        res = cur;
        if (w.bit_mode) begin
            res[w.bit_idx] = w.data[0];
        end else begin
            res = w.data;
        end
        return res;
    endfunction

    function automatic logic [PW-1:0] claimed_bits(input logic [PIDX_W-1:0] p,
        input logic [PW-1:0] mode);
        logic [PW-1:0] res;
        res = '0;
        if (p == P_CLOCK_PIN && mode != CLOCK_MODE_PORT) begin
            res = CLOCK_CLAIM_MASK;
        end
        return res;
    endfunction

    function automatic logic [PW-1:0] analog_bits(input logic [PIDX_W-1:0] p,
        input logic [PW-1:0] cfg);
        logic [PW-1:0] res;
        res = '0;
        if (p == P_ANALOG) begin
            res = cfg;
        end
        return res;
    endfunction

    // per-port implemented bits; an unknown port index decodes to no bits
    function automatic logic [PW-1:0] width_bits(input logic [PIDX_W-1:0] p);
        logic [PW-1:0] res;
        res = '0;
        if (p == P_FIRST) begin
            res = WIDTH_MASK[P_FIRST];
        end else if (p == P_SECOND) begin
            res = WIDTH_MASK[P_SECOND];
        end else if (p == P_ANALOG) begin
            res = WIDTH_MASK[P_ANALOG];
        end else if (p == P_FOURTH) begin
            res = WIDTH_MASK[P_FOURTH];
        end else if (p == P_OPEN_DRAIN) begin
            res = WIDTH_MASK[P_OPEN_DRAIN];
        end else if (p == P_KEY) begin
            res = WIDTH_MASK[P_KEY];
        end else if (p == P_CLOCK_PIN) begin
            res = WIDTH_MASK[P_CLOCK_PIN];
        end
        return res;
    endfunction

    // per-port pull-up option bits; ports without the option decode to none
    function automatic logic [PW-1:0] pull_bits(input logic [PIDX_W-1:0] p);
        logic [PW-1:0] res;
        res = '0;
        if (p == P_FIRST) begin
            res = PULL_MASK[P_FIRST];
        end else if (p == P_SECOND) begin
            res = PULL_MASK[P_SECOND];
        end else if (p == P_ANALOG) begin
            res = PULL_MASK[P_ANALOG];
        end else if (p == P_FOURTH) begin
            res = PULL_MASK[P_FOURTH];
        end else if (p == P_OPEN_DRAIN) begin
            res = PULL_MASK[P_OPEN_DRAIN];
        end else if (p == P_KEY) begin
            res = PULL_MASK[P_KEY];
        end else if (p == P_CLOCK_PIN) begin
            res = PULL_MASK[P_CLOCK_PIN];
        end
        return res;
    endfunction

    // indices above the last port select nothing
    function automatic logic port_valid(input logic [PIDX_W-1:0] p);
        return p < PIDX_W'(NPORT);
    endfunction

    function automatic logic is_analog_cfg(input gp_reg_e k, input logic [PIDX_W-1:0] p);
        return k == GP_REG_ANALOG && p == P_ANALOG;
    endfunction

    // ****************************************
    // control registers
    // ****************************************
    gp_bank_t dir_q, dir_d;
    gp_bank_t latch_q, latch_d;
    gp_bank_t pull_q, pull_d;
    logic [PW-1:0] analog_cfg_q, analog_cfg_d;

    always_comb begin
        dir_d = dir_q;
        latch_d = latch_q;
        pull_d = pull_q;
        analog_cfg_d = analog_cfg_q;
        if (wr_i.en && port_valid(wr_i.port)) begin
            if (wr_i.kind == GP_REG_DIR) begin
                dir_d[wr_i.port] = merge_write(dir_q[wr_i.port], wr_i) |
                    ~width_bits(wr_i.port);
            end else if (wr_i.kind == GP_REG_DATA) begin
                latch_d[wr_i.port] = merge_write(latch_q[wr_i.port], wr_i) &
                    width_bits(wr_i.port);
            end else if (wr_i.kind == GP_REG_PULL) begin
                // option bits only where a pull-up exists
                pull_d[wr_i.port] = merge_write(pull_q[wr_i.port], wr_i) &
                    pull_bits(wr_i.port);
            end else if (is_analog_cfg(wr_i.kind, wr_i.port)) begin
                analog_cfg_d = merge_write(analog_cfg_q, wr_i);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dir_q <= {NPORT{DIR_RESET}};
            latch_q <= {NPORT{LATCH_RESET}};
            pull_q <= {NPORT{PULL_RESET}};
            analog_cfg_q <= ANALOG_CFG_RESET;
        end else begin
            dir_q <= dir_d;
            latch_q <= latch_d;
            pull_q <= pull_d;
            analog_cfg_q <= analog_cfg_d;
        end
    end

    // ****************************************
    // pin input synchroniser
    // ****************************************
    gp_bank_t pin_meta_q, pin_meta_d;
    gp_bank_t pin_sync_q, pin_sync_d;

    // two stages before any logic reads a pin; only the second stage is used
    always_comb begin
        pin_meta_d = pin_i;
        pin_sync_d = pin_meta_q;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    // ****************************************
    // pad drive, per port
    // ****************************************
    gp_pad_s pad_d;
    gp_bank_t read_val;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic [PW-1:0] claim;
        logic [PW-1:0] analog;
        logic [PW-1:0] drive;
        logic [PW-1:0] impl_bits;
        logic [PW-1:0] pull_ok;
        assign impl_bits = width_bits(PIDX_W'(p));
        assign pull_ok = pull_bits(PIDX_W'(p));
        assign claim = claimed_bits(PIDX_W'(p), clock_mode_i);
        assign analog = analog_bits(PIDX_W'(p), analog_cfg_q);
        // direction zero turns the buffer on
        // claimed clock pins ignore direction and latch
        assign drive = ~dir_q[p] & impl_bits & ~claim;
        if (p == P_OPEN_DRAIN) begin : g_od
            // open drain pulls low only
            // a set latch releases the line; only the far side pulls it high
            assign pad_d.out[p] = '0;
            assign pad_d.oe[p] = drive & ~latch_q[p];
        end else begin : g_pp
            assign pad_d.out[p] = latch_q[p] & drive;
            assign pad_d.oe[p] = drive;
        end
        assign pad_d.pull[p] = pull_q[p] & pull_ok & dir_q[p] & ~analog & ~claim;
        // pin in input mode, latch in output mode
        assign read_val[p] = ((pin_sync_q[p] & dir_q[p] & ~analog) | (latch_q[p] & ~dir_q[p]))
            & impl_bits & ~claim;
    end

    // pads follow the control registers by one cycle so every pin comes from a flop
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pad_o <= '0;
        end else begin
            pad_o <= pad_d;
        end
    end

    // ****************************************
    // analog target and read port
    // ****************************************
    logic [PW-1:0] target_d;
    logic conflict_d;
    logic [PW-1:0] rd_d;
    logic [PW-1:0] chan_onehot;

    always_comb begin
        chan_onehot = '0;
        chan_onehot[channel_sel_i] = 1'b1;
        target_d = chan_onehot & analog_cfg_q & dir_q[P_ANALOG];
        conflict_d = |(chan_onehot & analog_cfg_q & ~dir_q[P_ANALOG]);
        rd_d = '0;
        if (!port_valid(rd_i.port)) begin
            rd_d = '0;
        end else if (rd_i.kind == GP_REG_DIR) begin
            rd_d = dir_q[rd_i.port];
        end else if (rd_i.kind == GP_REG_DATA) begin
            rd_d = read_val[rd_i.port];
        end else if (rd_i.kind == GP_REG_PULL) begin
            rd_d = pull_q[rd_i.port];
        end else if (is_analog_cfg(rd_i.kind, rd_i.port)) begin
            rd_d = analog_cfg_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rd_data_o <= '0;
            analog_target_o <= '0;
            analog_conflict_o <= 1'b0;
        end else begin
            rd_data_o <= rd_d;
            analog_target_o <= target_d;
            analog_conflict_o <= conflict_d;
        end
    end

endmodule

`default_nettype wire

// *** gp_monitor.sv ***
// checker of gp_gpio port relations
// assumes one clock; bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module gp_monitor
    import gp_pkg::*;
(
    input wire logic clock_i, // clock
    input wire logic reset_i, // reset
    input wire gp_pkg::gp_wr_s wr_i, // write
    input wire gp_pkg::gp_rd_s rd_i, // read select
    input wire logic [PW-1:0] rd_data_o, // read data
    input wire gp_pkg::gp_bank_t pin_i, // pins
    input wire gp_pkg::gp_pad_s pad_o, // pads
    input wire logic [PW-1:0] clock_mode_i, // clock mode
    input wire logic [BIT_W-1:0] channel_sel_i, // channel
    input wire logic [PW-1:0] analog_target_o, // target
    input wire logic analog_conflict_o // conflict
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> pad_o == '0)
        else $error("pads active after reset");
    a_od_low_only: assert property (pad_o.out[P_OPEN_DRAIN] == 8'h00)
        else $error("open-drain pin driven high");
    a_width_oe: assert property (!pad_o.oe[P_FIRST][7] && pad_o.oe[P_FOURTH][7:4] == 4'h0)
        else $error("unimplemented bit driven");
    a_pull_cut: assert property ((pad_o.pull & pad_o.oe) == '0)
        else $error("pull-up on a driven pin");
    a_pull_absent: assert property (pad_o.pull[P_ANALOG] == 8'h00
        && pad_o.pull[P_CLOCK_PIN][7:1] == 7'h00)
        else $error("pull-up where none exists");
    a_out_needs_oe: assert property ((pad_o.out & ~pad_o.oe) == '0)
        else $error("drive level without enable");
    a_clock_claim: assert property ($past(clock_mode_i) != 8'h00
        |-> (pad_o.oe[P_CLOCK_PIN] & CLOCK_CLAIM_MASK) == 8'h00)
        else $error("claimed clock pin driven");
    a_target_sel: assert property (analog_target_o != 8'h00
        |-> analog_target_o == (8'h01 << $past(channel_sel_i)) && !analog_conflict_o)
        else $error("target not the selected channel");
endmodule
`default_nettype wire

// *** gp_pins.sv ***
// far-side pin model: resolves pad drive, external drive and pull-ups
// assumes pad_o of gp_gpio on the same clock
`timescale 1ns/100ps
`default_nettype none
module gp_pins
    import gp_pkg::*;
(
    input wire logic clock_i, // clock
    input wire gp_pkg::gp_pad_s pad_i, // pad drive
    input wire gp_pkg::gp_bank_t ext_en_i, // far side drives
    input wire gp_pkg::gp_bank_t ext_val_i, // far side level
    output var gp_pkg::gp_bank_t pin_o // pin level
);
    gp_bank_t last_q = '0;
    // open-drain enable pulls low
    // a floating pin toggles so no level is read by luck
    assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_val_i)
        | (~pad_i.oe & ~ext_en_i & (pad_i.pull | ~last_q));
    always_ff @(posedge clock_i) begin
        last_q <= pin_o;
    end
endmodule
`default_nettype wire

// *** gp_gpio_tb.sv ***
// self-checking bench of gp_gpio with far-side pin model
// assumes gp_pkg, gp_pins and gp_monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module gp_gpio_tb;
    import gp_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    gp_wr_s wr_i = '0;
    gp_rd_s rd_i = '0;
    gp_bank_t pin_i;
    gp_pad_s pad_o;
    logic [PW-1:0] rd_data_o;
    logic [PW-1:0] analog_target_o;
    logic [PW-1:0] clock_mode_i = 8'h00;
    logic [BIT_W-1:0] channel_sel_i = 3'h0;
    logic analog_conflict_o;
    gp_bank_t ext_en = '0;
    gp_bank_t ext_val = '0;
    logic [PW-1:0] got;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    always #2 clock_i = ~clock_i;
    gp_gpio dut (.clock_i(clock_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .pin_i(pin_i), .pad_o(pad_o), .clock_mode_i(clock_mode_i),
        .channel_sel_i(channel_sel_i), .analog_target_o(analog_target_o),
        .analog_conflict_o(analog_conflict_o));
    gp_pins far (.clock_i(clock_i), .pad_i(pad_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_o(pin_i));
    task automatic report_and_stop();
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [PW-1:0] g, input logic [PW-1:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input gp_reg_e k, input logic [2:0] p, input logic [7:0] d,
        input logic bm = 1'b0, input logic [2:0] b = 3'h0);
        @(posedge clock_i);
        wr_i <= '{1'b1, bm, k, p, b, d};
        @(posedge clock_i);
        wr_i.en <= 1'b0;
    endtask
    task automatic rd(input gp_reg_e k, input logic [2:0] p);
        @(posedge clock_i);
        rd_i <= '{k, p};
        @(posedge clock_i);
        #1 got = rd_data_o;
    endtask
    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            rd(GP_REG_DIR, p[2:0]);
            chk(got, 8'hff);
        end
        rd(GP_REG_ANALOG, P_ANALOG);
        chk(got, 8'hff);
        wr(GP_REG_DIR, P_FIRST, 8'h00);
        wr(GP_REG_DATA, P_FIRST, 8'hff);
        settle();
        chk(pad_o.oe[P_FIRST], 8'h7f);
        wr(GP_REG_DATA, P_FIRST, 8'h00, 1'b1, 3'h3);
        rd(GP_REG_DATA, P_FIRST);
        chk(got, 8'h77);
        wr(GP_REG_DIR, P_FIRST, 8'h0f);
        wr(GP_REG_DIR, P_SECOND, 8'h00);
        wr(GP_REG_DATA, P_SECOND, 8'ha5);
        for (int p = 0; p < NPORT; p++) begin
            wr(GP_REG_PULL, p[2:0], 8'hff);
            rd(GP_REG_PULL, p[2:0]);
            chk(got, PULL_MASK[p]);
        end
        chk(pad_o.pull[P_FIRST], 8'h0f);
        chk(pad_o.out[P_SECOND], 8'ha5);
        rd(GP_REG_DATA, P_KEY);
        chk(got, 8'hff);
        rd(GP_REG_DATA, P_FIRST);
        chk(got, 8'h7f);
        @(posedge clock_i);
        ext_en[P_FOURTH] <= 8'h0f;
        ext_val[P_FOURTH] <= 8'h0a;
        repeat (2) @(posedge clock_i);
        rd(GP_REG_DATA, P_FOURTH);
        chk(got, 8'h0a);
        wr(GP_REG_DIR, P_OPEN_DRAIN, 8'h00);
        wr(GP_REG_DATA, P_OPEN_DRAIN, 8'h01);
        settle();
        chk(pad_o.oe[P_OPEN_DRAIN], 8'h02);
        wr(GP_REG_ANALOG, P_ANALOG, 8'hf0);
        wr(GP_REG_DIR, P_ANALOG, 8'hfe);
        @(posedge clock_i);
        channel_sel_i <= 3'h4;
        settle();
        chk(analog_target_o, 8'h10);
        wr(GP_REG_DIR, P_ANALOG, 8'hee);
        settle();
        chk(8'(analog_conflict_o), 8'h01);
        chk(analog_target_o, 8'h00);
        wr(GP_REG_DIR, P_ANALOG, 8'hfe);
        wr(GP_REG_DIR, P_CLOCK_PIN, 8'h00);
        settle();
        chk(pad_o.oe[P_CLOCK_PIN], 8'h1f);
        @(posedge clock_i);
        clock_mode_i <= 8'h01;
        settle();
        chk(pad_o.oe[P_CLOCK_PIN], 8'h01);
        report_and_stop();
    end
endmodule
bind gp_gpio gp_monitor mon (.clock_i(clock_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .pin_i(pin_i), .pad_o(pad_o), .clock_mode_i(clock_mode_i),
    .channel_sel_i(channel_sel_i), .analog_target_o(analog_target_o),
    .analog_conflict_o(analog_conflict_o));
`default_nettype wire
